/* pkg/lbpc_pkg.sv */
// Notes on behaviour
// - Source field code 0 selects the fast oscillator, code 1 the slow one, 2 and 3 reserved, reset 0.
// - On the fast oscillator, ratio codes 0 to 6 divide by 64 up to 4096, code 7 is reserved, reset 0.
// - On the slow oscillator, ratio codes 0 to 3 divide by 8 up to 64, codes 4 to 7 are reserved.
// - The enable bit resets to 0 with the clock held off, 1 passes the divided clock, 0 stops it.
// - The reference select bit picks the lower level at 0 and the higher level at 1, reset 0.
// - Each regulator's strong-mode bit at 1 commands that regulator into protection mode.
// - The three registers decode at addresses 0x5071, 0x50A3 and 0x5120; here word indices, decoded at byte addresses 0x141C4, 0x1428C and 0x14480.
// - The core regulator always runs and only its protection mode is programmable.
// - Each register is an 8-bit device moved in a single bus access.
// - Booster control holds ratio in bits 6..4, source in bits 3..2, enable in bit 0, bits 7 and 1 read 0.
// - LCD regulator control holds strong mode in bit 4 and reference select in bit 0, others read 0.
package lbpc_pkg;

  // Register indices; one aligned word each, so byte address is four times the index
  localparam logic [15:0] LBPC_BCLK_IDX  = 16'h5071;
  localparam logic [15:0] LBPC_VREG_IDX  = 16'h50A3;
  localparam logic [15:0] LBPC_CORE_IDX  = 16'h5120;

  // Byte addresses of the registers
  localparam logic [17:0] LBPC_BCLK_ADDR = {LBPC_BCLK_IDX, 2'b00};
  localparam logic [17:0] LBPC_VREG_ADDR = {LBPC_VREG_IDX, 2'b00};
  localparam logic [17:0] LBPC_CORE_ADDR = {LBPC_CORE_IDX, 2'b00};

  // Field positions
  localparam int LBPC_DIV_LSB  = 4;
  localparam int LBPC_SRC_LSB  = 2;
  localparam int LBPC_ON_BIT   = 0;
  localparam int LBPC_LSTR_BIT = 4;
  localparam int LBPC_REF_BIT  = 0;
  localparam int LBPC_CSTR_BIT = 5;

  // Reset values
  localparam logic [2:0] LBPC_DIV_RST = 3'h0;
  localparam logic [1:0] LBPC_SRC_RST = 2'h0;

  // Source codes
  localparam logic [1:0] LBPC_SRC_FAST = 2'h0;
  localparam logic [1:0] LBPC_SRC_SLOW = 2'h1;

  // Divide exponents at code 0: 2^6 fast, 2^3 slow
  localparam logic [3:0] LBPC_FAST_EXP0 = 4'h6;
  localparam logic [3:0] LBPC_SLOW_EXP0 = 4'h3;
  localparam logic [2:0] LBPC_FAST_MAXC = 3'h6;
  localparam logic [2:0] LBPC_SLOW_MAXC = 3'h3;

  // Control fields
  typedef struct packed {
    logic [2:0] div_sel;
    logic [1:0] src_sel;
    logic       clk_on;
  } lbpc_bclk_s;

  // Regulator commands
  typedef struct packed {
    logic ref_level_sel;
    logic lcd_reg_strong_mode;
    logic core_reg_strong_mode;
  } lbpc_reg_s;

endpackage

/* hdl/lbpc_divider.sv */
`timescale 1ns/1ns
module lbpc_divider (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire lbpc_pkg::lbpc_bclk_s cfg,
  input  wire logic              fast_tick,
  input  wire logic              slow_tick,
  output logic                   div_out
);
  import lbpc_pkg::*;

  logic [11:0] cnt_r;
  logic [3:0]  exp_w;
  logic        valid_w;
  logic        tick_w;

  // Exponent of the division and reserved-code detection
  always_comb begin
    exp_w   = 4'h0;
    valid_w = 1'b0;
    tick_w  = 1'b0;
    if (cfg.src_sel == LBPC_SRC_FAST) begin
      exp_w   = LBPC_FAST_EXP0 + {1'b0, cfg.div_sel};
      valid_w = (cfg.div_sel <= LBPC_FAST_MAXC);
      tick_w  = fast_tick;
    end else if (cfg.src_sel == LBPC_SRC_SLOW) begin
      exp_w   = LBPC_SLOW_EXP0 + {1'b0, cfg.div_sel};
      valid_w = (cfg.div_sel <= LBPC_SLOW_MAXC);
      tick_w  = slow_tick;
    end
  end

  // Synchronous counter stepped by source edges; held clear when off or reserved
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 12'h000;
    end else if (!cfg.clk_on || !valid_w) begin
      cnt_r <= 12'h000;
    end else if (tick_w) begin
      cnt_r <= cnt_r + 12'h001;
    end
  end

  // Output is the counter bit one below the exponent: period 2^exp edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_out <= 1'b0;
    end else if (!cfg.clk_on || !valid_w) begin
      div_out <= 1'b0;
    end else begin
      div_out <= cnt_r[exp_w - 4'h1];
    end
  end

endmodule

/* hdl/lbpc_top.sv */
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
module lbpc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        fast_osc_b,
  input  wire logic        slow_osc_a,
  output logic             booster_clk,
  output logic             ref_level_sel,
  output logic             lcd_reg_strong_mode,
  output logic             core_reg_strong_mode
);
  import lbpc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Oscillator synchronisers and edge detect

  logic [1:0]  fast_sync_r;
  logic [1:0]  slow_sync_r;
  logic        fast_last_r;
  logic        slow_last_r;
  logic        fast_tick;
  logic        slow_tick;

  // Two flops before use; edge detector reads only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_sync_r <= 2'h0;
      slow_sync_r <= 2'h0;
      fast_last_r <= 1'b0;
      slow_last_r <= 1'b0;
    end else begin
      fast_sync_r <= {fast_sync_r[0], fast_osc_b};
      slow_sync_r <= {slow_sync_r[0], slow_osc_a};
      fast_last_r <= fast_sync_r[1];
      slow_last_r <= slow_sync_r[1];
    end
  end

  // Rising edges; source must run below half of pclk
  assign fast_tick = fast_sync_r[1] & ~fast_last_r;
  assign slow_tick = slow_sync_r[1] & ~slow_last_r;

  ////////////////////////////////////////////////////////////////////////
  // Register file

  lbpc_bclk_s bclk_r;
  lbpc_reg_s  reg_r;
  logic       wr_en;
  logic       hit_bclk;
  logic       hit_vreg;
  logic       hit_core;
  logic       hit_any;
  logic [7:0] rd_byte;

  // Address decode, one byte per access
  assign hit_bclk = (paddr == LBPC_BCLK_ADDR);
  assign hit_vreg = (paddr == LBPC_VREG_ADDR);
  assign hit_core = (paddr == LBPC_CORE_ADDR);
  assign hit_any  = hit_bclk | hit_vreg | hit_core;
  assign wr_en    = psel & penable & pwrite & hit_any;

  // Booster control fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bclk_r.div_sel <= LBPC_DIV_RST;
      bclk_r.src_sel <= LBPC_SRC_RST;
      bclk_r.clk_on  <= 1'b0;
    end else if (wr_en && hit_bclk) begin
      bclk_r.div_sel <= pwdata[LBPC_DIV_LSB +: 3];
      bclk_r.src_sel <= pwdata[LBPC_SRC_LSB +: 2];
      bclk_r.clk_on  <= pwdata[LBPC_ON_BIT];
    end
  end

  // Regulator control bits; core regulator has no off bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_r <= '0;
    end else if (wr_en && hit_vreg) begin
      reg_r.ref_level_sel       <= pwdata[LBPC_REF_BIT];
      reg_r.lcd_reg_strong_mode <= pwdata[LBPC_LSTR_BIT];
    end else if (wr_en && hit_core) begin
      reg_r.core_reg_strong_mode <= pwdata[LBPC_CSTR_BIT];
    end
  end

  // Read mux; reserved bits read zero
  always_comb begin
    rd_byte = 8'h00;
    if (hit_bclk) begin
      rd_byte[LBPC_DIV_LSB +: 3] = bclk_r.div_sel;
      rd_byte[LBPC_SRC_LSB +: 2] = bclk_r.src_sel;
      rd_byte[LBPC_ON_BIT]       = bclk_r.clk_on;
    end else if (hit_vreg) begin
      rd_byte[LBPC_REF_BIT]  = reg_r.ref_level_sel;
      rd_byte[LBPC_LSTR_BIT] = reg_r.lcd_reg_strong_mode;
    end else if (hit_core) begin
      rd_byte[LBPC_CSTR_BIT] = reg_r.core_reg_strong_mode;
    end
  end

  // APB answer: zero wait; registered so outputs come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_any;
      prdata  <= (psel & ~penable & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Divider and outputs

  logic div_w;

  lbpc_divider u_div (
    .pclk      (pclk),
    .presetn   (presetn),
    .cfg       (bclk_r),
    .fast_tick (fast_tick),
    .slow_tick (slow_tick),
    .div_out   (div_w)
  );

  // Outputs from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      booster_clk          <= 1'b0;
      ref_level_sel        <= 1'b0;
      lcd_reg_strong_mode  <= 1'b0;
      core_reg_strong_mode <= 1'b0;
    end else begin
      booster_clk          <= div_w & bclk_r.clk_on;
      ref_level_sel        <= reg_r.ref_level_sel;
      lcd_reg_strong_mode  <= reg_r.lcd_reg_strong_mode;
      core_reg_strong_mode <= reg_r.core_reg_strong_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  chk_off_low: assert property (@(posedge pclk) disable iff (!presetn)
    !bclk_r.clk_on |=> ##1 !booster_clk) else $error("booster clock ran while off");
  chk_ref_follow: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit_vreg |=> ##1 ref_level_sel == $past(pwdata[0], 2))
    else $error("reference select lag wrong");
  chk_lcd_strong: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit_vreg |=> ##1 lcd_reg_strong_mode == $past(pwdata[4], 2))
    else $error("lcd strong mode wrong");
  chk_core_strong: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit_core |=> ##1 core_reg_strong_mode == $past(pwdata[5], 2))
    else $error("core strong mode wrong");
  chk_cnt_held: assert property (@(posedge pclk) disable iff (!presetn)
    !bclk_r.clk_on |=> u_div.cnt_r == 12'h000) else $error("counter not held");
  chk_reserved_off: assert property (@(posedge pclk) disable iff (!presetn)
    bclk_r.src_sel == LBPC_SRC_FAST && bclk_r.div_sel == 3'h7 |=> ##1 !booster_clk)
    else $error("reserved ratio produced clock");
  chk_slow_rsv: assert property (@(posedge pclk) disable iff (!presetn)
    bclk_r.src_sel == LBPC_SRC_SLOW && bclk_r.div_sel[2] |=> ##1 !booster_clk)
    else $error("reserved slow ratio produced clock");
  chk_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && hit_bclk |=> prdata[7] == 1'b0 && prdata[1] == 1'b0
      && pready) else $error("reserved bits nonzero");
  chk_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !hit_any |=> pslverr) else $error("unmapped not flagged");

  // Error only ever answers a setup that missed every register
  chk_err_cause: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> $past(psel && !penable && !hit_any))
    else $error("error flagged on a mapped address");

  // A write to a hole must leave every register alone
  chk_no_wr_miss: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && !hit_any |=> $stable(bclk_r) && $stable(reg_r))
    else $error("unmapped write changed a register");

  // Registers only move in an access cycle; setup alone must not write
  chk_wr_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !(psel && penable) |=> $stable(bclk_r) && $stable(reg_r))
    else $error("register moved outside an access");

  // Ready answers exactly one access cycle
  chk_pready_once: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready) else $error("ready stood longer than one cycle");

  // Byte-wide device: the upper lanes always read zero
  chk_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> prdata[31:8] == 24'h00_0000) else $error("read data above one byte");

  // Booster control write lands whole, in its own field positions
  chk_bclk_store: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit_bclk |=>
      bclk_r == {$past(pwdata[6:4]), $past(pwdata[3:2]), $past(pwdata[0])})
    else $error("booster control fields stored wrong");

  // Booster control read returns the stored fields
  chk_bclk_read: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && hit_bclk |=>
      prdata[6:0] == {$past(bclk_r.div_sel), $past(bclk_r.src_sel), 1'b0,
                      $past(bclk_r.clk_on)})
    else $error("booster control read wrong");

  // Regulator control: only bits 4 and 0 exist
  chk_vreg_zero: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && hit_vreg |=>
      prdata[7:5] == 3'h0 && prdata[3:1] == 3'h0)
    else $error("reserved regulator bits nonzero");

  chk_vreg_read: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && hit_vreg |=>
      prdata[4] == $past(reg_r.lcd_reg_strong_mode) && prdata[0] == $past(reg_r.ref_level_sel))
    else $error("regulator control read wrong");

  // Core control: no off bit, the strong bit is all there is
  chk_core_zero: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && hit_core |=>
      prdata[7:6] == 2'h0 && prdata[4:0] == 5'h00
      && prdata[5] == $past(reg_r.core_reg_strong_mode))
    else $error("core control read wrong");

  // Reserved source codes keep the booster quiet
  chk_src_rsv: assert property (@(posedge pclk) disable iff (!presetn)
    bclk_r.src_sel[1] |=> ##1 !booster_clk) else $error("reserved source produced clock");

  // A rise needs the enable standing when it was launched
  chk_rise_on: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(booster_clk) |-> $past(bclk_r.clk_on)) else $error("booster rose while disabled");

  // Divider output itself is held low while off, not only the gated pin
  chk_div_held: assert property (@(posedge pclk) disable iff (!presetn)
    !bclk_r.clk_on |=> !u_div.div_out) else $error("divider output ran while off");

  ////////////////////////////////////////////////////////////////////////
  // Booster rise spacing monitor

  logic [3:0] rise_gap_r;
  logic       booster_last_r;
  logic       cfg_wr_seen_r;
  logic       booster_rise;

  // Pin edge; the pin's idle level is low so reset value matches
  assign booster_rise = booster_clk & ~booster_last_r;

  // Cycles since the last rise, saturating; fifteen is enough to prove
  // the shortest legal period of eight source edges at two pclk each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_gap_r     <= 4'hF;
      booster_last_r <= 1'b0;
    end else begin
      booster_last_r <= booster_clk;
      if (booster_rise) begin
        rise_gap_r <= 4'h0;
      end else if (rise_gap_r != 4'hF) begin
        rise_gap_r <= rise_gap_r + 4'h1;
      end
    end
  end

  // A config write can shift the phase, so that period is exempt; a write
  // in the cycle of a rise wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_wr_seen_r <= 1'b0;
    end else if (wr_en && hit_bclk) begin
      cfg_wr_seen_r <= 1'b1;
    end else if (booster_rise) begin
      cfg_wr_seen_r <= 1'b0;
    end
  end

  // With a steady config no two rises come closer than sixteen cycles
  chk_rise_gap: assert property (@(posedge pclk) disable iff (!presetn)
    booster_rise && !cfg_wr_seen_r |-> rise_gap_r == 4'hF)
    else $error("booster period shorter than any legal ratio");

  cov_enable: cover property (@(posedge pclk) disable iff (!presetn) $rose(booster_clk));
  cov_slow: cover property (@(posedge pclk) disable iff (!presetn)
    bclk_r.src_sel == LBPC_SRC_SLOW && booster_clk);
  cov_core: cover property (@(posedge pclk) disable iff (!presetn) core_reg_strong_mode);
  cov_miss: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
  cov_rsv_on: cover property (@(posedge pclk) disable iff (!presetn)
    bclk_r.clk_on && bclk_r.div_sel == 3'h7);

endmodule

/* verif/tb_lcd_booster_power_control.sv */
`timescale 1ns/1ns
module tb_lcd_booster_power_control;
  import lbpc_pkg::*;
  typedef struct packed {
    logic [17:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        err;
    logic [2:0]  outs;
  } lbpc_tb_row_s;
  // Reserved bits always written zero, then unmapped places; outs = ref, lcd, core
  localparam lbpc_tb_row_s ROWS [8] = '{
    '{18'h1428C, 8'h11, 8'h11, 1'b0, 3'b110}, '{18'h14480, 8'h20, 8'h20, 1'b0, 3'b111},
    '{18'h1428C, 8'h00, 8'h00, 1'b0, 3'b001}, '{18'h14480, 8'h00, 8'h00, 1'b0, 3'b000},
    '{18'h141C4, 8'h7C, 8'h7C, 1'b0, 3'b000}, '{18'h141C4, 8'h00, 8'h00, 1'b0, 3'b000},
    '{18'h141C0, 8'hFF, 8'h00, 1'b1, 3'b000}, '{18'h14288, 8'hFF, 8'h00, 1'b1, 3'b000}};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [17:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        fast_osc_b = 1'b0;
  logic        slow_osc_a = 1'b0;
  logic        booster_clk;
  logic        ref_level_sel;
  logic        lcd_reg_strong_mode;
  logic        core_reg_strong_mode;
  logic [2:0]  osc_cnt = 3'h0;
  int          err_count = 0;
  int          checked = 0;
  int          cycles = 0;
  logic [31:0] rd;
  logic        er;
  int          n;
  lbpc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fast_osc_b(fast_osc_b), .slow_osc_a(slow_osc_a),
    .booster_clk(booster_clk), .ref_level_sel(ref_level_sel),
    .lcd_reg_strong_mode(lcd_reg_strong_mode), .core_reg_strong_mode(core_reg_strong_mode));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, slow enough oscillators (fast = pclk/4, slow = pclk/8) and the run limit
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    osc_cnt <= osc_cnt + 3'h1;
    fast_osc_b <= osc_cnt[1];
    slow_osc_a <= osc_cnt[2];
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_count++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic wr, input logic [17:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    int w;
    w = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && w < 16) begin
      @(posedge pclk);
      w++;
    end
    if (w >= 16) err_count++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Cycles until the next rising edge of the booster clock, capped at 2000
  task automatic wait_rise(output int c);
    logic prev;
    c = 0;
    prev = booster_clk;
    while (c < 2000) begin
      @(posedge pclk);
      c++;
      if (booster_clk === 1'b1 && prev !== 1'b1) break;
      prev = booster_clk;
    end
  endtask
  // Period check; exp of 2000 means the output must never rise
  task automatic measure(input logic [7:0] cfg, input int exp);
    apb(1'b1, LBPC_BCLK_ADDR, cfg, rd, er);
    wait_rise(n);
    if (exp != 2000) wait_rise(n);
    check(n, exp);
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values through the bus and at the outputs
    apb(1'b0, LBPC_BCLK_ADDR, 8'h00, rd, er);
    check(rd, 32'h0000_0000);
    apb(1'b0, LBPC_VREG_ADDR, 8'h00, rd, er);
    check(rd, 32'h0000_0000);
    check({booster_clk, ref_level_sel, lcd_reg_strong_mode, core_reg_strong_mode}, 0);
    // Table rows: write, read back, check flag and levels
    foreach (ROWS[i]) begin
      apb(1'b1, ROWS[i].addr, ROWS[i].wdata, rd, er);
      check(er, ROWS[i].err);
      apb(1'b0, ROWS[i].addr, 8'h00, rd, er);
      check(rd, {24'h00_0000, ROWS[i].rdata});
      check({ref_level_sel, lcd_reg_strong_mode, core_reg_strong_mode}, ROWS[i].outs);
    end
    // Periods in pclk cycles: fast edge = 4, slow edge = 8
    // Oscillators are scaled down; on silicon these ratios land in the allowed band
    measure(8'h01, 256);
    measure(8'h11, 512);
    measure(8'h05, 64);
    measure(8'h35, 512);
    // Reserved codes and a cleared enable keep the output low
    measure(8'h71, 2000);
    measure(8'h45, 2000);
    measure(8'h09, 2000);
    measure(8'h10, 2000);
    // Reset in mid-run clears everything
    apb(1'b1, LBPC_VREG_ADDR, 8'h11, rd, er);
    apb(1'b1, LBPC_BCLK_ADDR, 8'h05, rd, er);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check({booster_clk, ref_level_sel, lcd_reg_strong_mode}, 0);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, LBPC_BCLK_ADDR, 8'h00, rd, er);
    check(rd, 32'h0000_0000);
    complete_run();
  end
endmodule
